/* File: hw/pcmsig_defs.svh */
// Constants of the PCM signaling-bit port
`ifndef PCMSIG_DEFS_SVH
`define PCMSIG_DEFS_SVH
// Bits in one PCM word
`define PCMSIG_WORD_W 8
// Bit positions within a PCM word
`define PCMSIG_MSB 7
`define PCMSIG_LSB 0
// Frame sync widths in bit clock periods
`define PCMSIG_SHORT_W 2'd1
`define PCMSIG_SIG_W 2'd2
`define PCMSIG_LONG_W 2'd3
// System clock period in ns
`define PCMSIG_CLK_PERIOD_NS 20
// Decoder update delay in us, and in system clocks
`define PCMSIG_DEC_US 10
`define PCMSIG_DEC_CYC (`PCMSIG_DEC_US * 1000 / `PCMSIG_CLK_PERIOD_NS)
// Master clock edges per filter clock half period (2.048 MHz to 256 kHz)
`define PCMSIG_FILT_HALF 4
// Reset value of the transmit code
`define PCMSIG_CODE_RST 8'hff
`endif

/* File: hw/pcmsig_pkg.sv */
// Types shared by the PCM signaling-bit port
`default_nettype none
package pcmsig_pkg;
   // One companded PCM word
   typedef logic [7:0] pcmsig_word_t;
   // Decoded code with one half-step fractional bit
   typedef logic [8:0] pcmsig_dec_t;
   // Shifter states, one-hot
   typedef enum logic [1:0] {
      st_idle = 2'b01,
      st_shift = 2'b10
   } pcmsig_state_t;
endpackage
`default_nettype wire

/* File: hw/pcmsig_buf_if.sv */
// Valid/ready carrier between the port and its two-entry buffer
`default_nettype none
interface pcmsig_buf_if;
   // Filling side
   pcmsig_pkg::pcmsig_dec_t in_data;
   logic in_valid;
   logic in_ready;
   // Draining side
   pcmsig_pkg::pcmsig_dec_t out_data;
   logic out_valid;
   logic out_ready;
   modport fill (output in_data, output in_valid, input in_ready);
   modport store (input in_data, input in_valid, output in_ready,
                  output out_data, output out_valid, input out_ready);
   modport drain (input out_data, input out_valid, output out_ready);
endinterface
`default_nettype wire

/* File: hw/pcmsig_fifo2.sv */
// Two-entry buffer with registered read data
`default_nettype none
module pcmsig_fifo2 (
   // Clock, reset, enable
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // Buffer ports
   pcmsig_buf_if.store bus
);
   // Second entry waiting behind the head
   pcmsig_pkg::pcmsig_dec_t tail;
   logic tail_valid;
   logic push;
   logic pop;

   // Full when the second entry is occupied
   assign bus.in_ready = !tail_valid;
   assign push = bus.in_valid && !tail_valid;
   assign pop = bus.out_valid && bus.out_ready;

   // Head and tail update
   always_ff @(posedge clk) begin
      if (rst) begin
         bus.out_valid <= 1'b0;
         bus.out_data <= '0;
         tail_valid <= 1'b0;
         tail <= '0;
      end else if (ce) begin
         if (pop) begin
            // Tail moves up and the tail empties, or with no tail the new word goes straight to the head
            if (tail_valid) begin
               bus.out_data <= tail;
               tail <= bus.in_data;
               tail_valid <= push;
            end else begin
               bus.out_data <= bus.in_data;
               bus.out_valid <= push;
            end
         end else if (push) begin
            if (!bus.out_valid) begin
               bus.out_data <= bus.in_data;
               bus.out_valid <= 1'b1;
            end else begin
               tail <= bus.in_data;
               tail_valid <= 1'b1;
            end
         end
      end
   end

   // Held word stays put while the reader stalls
   a_head_stable: assert property (@(posedge clk) disable iff (rst || !ce)
      bus.out_valid && !bus.out_ready |=> bus.out_valid && $stable(bus.out_data))
      else $error("buffer head changed under stall");
endmodule
`default_nettype wire

/* File: hw/pcmsig_port.sv */
// PCM highway port with signaling-bit insertion and extraction
`include "pcmsig_defs.svh"
`default_nettype none
// Contract
// R1: two-period transmit sync inserts signaling LSB
// R2: two-period receive sync latches LSB out (code: only while long_mode is clear)
// R3: signaling frame decodes LSB as half step
// R4: controller holds markers low for short signaling
// R5: short-only variant never signals in long mode
// R6: long mode transmit marker inserts signaling LSB
// R7: long mode receive marker latches LSB out
// R8: code sent one frame after encoding
// R9: eight falling edges capture receive word
// R10: decoder output updates 10 us after slot
// R11: master clock divided to 256 kHz filter clock
// R12: sense frame style, start in short mode
// R13: rising-edge shift, release after eight periods
// R14: measure sync width in bit periods
// R15: signaling output changes only on signaling frames
module pcmsig_port #(
   // Long-frame marker support (0 gives the short-frame-only variant)
   parameter bit LONG_SIG_EN = 1'b1
) (
   // System side
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // Codes from the encoder
   input wire logic [7:0] tx_code,
   input wire logic tx_code_valid,
   output logic tx_code_ready,
   // Codes to the decoder
   output logic [8:0] rx_sample,
   output logic rx_sample_valid,
   input wire logic rx_sample_ready,
   // Master clock and filter step clock
   input wire logic tx_master_clock,
   output logic filter_clock,
   // PCM highway, all timed by the bit clock
   input wire logic tx_bit_clock,
   input wire logic tx_frame_sync,
   input wire logic rx_frame_sync,
   input wire logic tx_signaling_frame_mark,
   input wire logic rx_signaling_frame_mark,
   input wire logic tx_signal_bit_in,
   input wire logic rx_pcm_in,
   output logic tx_pcm_out,
   output logic tx_pcm_oe,
   output logic rx_signal_bit_out
);
   // Delay bounds for checks
   localparam int DEC_MAX = 501;

   // ---------------- Link-domain signals ----------------
   logic lrst_1, lrst; // Reset carried into the bit clock domain
   logic lce_1, lce; // Enable carried into the bit clock domain
   logic sig_1, sig_in; // Signaling input synchroniser
   logic txfs_q; // Transmit sync seen at last falling edge
   logic [1:0] txw; // Transmit sync width so far
   logic long_mode; // Long frame style detected
   logic tx_sig; // Current transmit frame is a signaling frame
   pcmsig_pkg::pcmsig_state_t tx_st; // Transmit shifter state
   logic [2:0] tcnt; // Transmit bit index
   pcmsig_pkg::pcmsig_word_t tsh; // Transmit shift register
   logic tx_tog; // Flips at each transmit frame start
   logic rxfs_q; // Receive sync seen at last falling edge
   logic [1:0] rxw; // Receive sync width so far
   logic rx_sig; // Current receive frame is a signaling frame
   pcmsig_pkg::pcmsig_state_t rx_st; // Receive shifter state
   logic [2:0] rcnt; // Receive bit index
   logic [6:0] rsh; // Receive shift register
   pcmsig_pkg::pcmsig_dec_t rx_hold; // Completed word, stable for a frame
   logic rx_tog; // Flips when a receive word completes
   logic tx_start; // Transmit frame begins at this rising edge
   logic rx_fin; // Eighth receive bit at this falling edge

   // ---------------- System-domain signals ----------------
   logic [2:0] txt_s; // Transmit toggle synchroniser and edge
   logic [2:0] rxt_s; // Receive toggle synchroniser and edge
   logic tx_ev, rx_ev; // Frame events in the system domain
   pcmsig_pkg::pcmsig_word_t pend; // Latest code offered by the encoder
   pcmsig_pkg::pcmsig_word_t out_word; // Code shifted out at the next frame
   logic [8:0] dec_cnt; // Decoder update timer
   logic push_v; // Decoded word offered to the buffer
   pcmsig_pkg::pcmsig_dec_t push_d; // Decoded word
   logic [2:0] mck_s; // Master clock synchroniser and edge
   logic [2:0] fdiv; // Master edges in this filter half period
   pcmsig_buf_if rxb ();

   assign tx_ev = txt_s[1] ^ txt_s[2];
   assign rx_ev = rxt_s[1] ^ rxt_s[2];
   assign tx_start = txfs_q && (tx_st == pcmsig_pkg::st_idle);
   assign rx_fin = (rx_st == pcmsig_pkg::st_shift) && (rcnt == 3'd7);

   // Reset, enable and signaling input brought into the bit clock domain
   always_ff @(posedge tx_bit_clock) begin
      lrst_1 <= rst;
      lrst <= lrst_1;
      lce_1 <= ce;
      lce <= lce_1;
      sig_1 <= tx_signal_bit_in;
      sig_in <= sig_1;
   end

   // Transmit sync width and frame style, sampled on falling edges
   always_ff @(negedge tx_bit_clock) begin
      if (lrst) begin
         txfs_q <= 1'b0;
         txw <= 2'd0;
         long_mode <= 1'b0;
         tx_sig <= 1'b0;
      end else if (lce) begin
         txfs_q <= tx_frame_sync;
         if (tx_frame_sync) begin
            // R14: count sync width
            txw <= (txw == `PCMSIG_LONG_W) ? txw : txw + 2'd1;
            if (!txfs_q) begin
               tx_sig <= 1'b0;
            end else if (long_mode && LONG_SIG_EN && tx_signaling_frame_mark) begin
               // R6: marker flags signaling frame
               tx_sig <= 1'b1;
            end
         end else begin
            txw <= 2'd0;
            if (txfs_q) begin
               // R12: style sensed at each sync end
               long_mode <= (txw >= `PCMSIG_LONG_W);
               // R1: two-period sync flags signaling
               // R4: markers ignored in short mode
               if (txw == `PCMSIG_SIG_W) begin
                  tx_sig <= 1'b1;
               end
            end
         end
      end
   end

   // Transmit shifter on rising edges
   always_ff @(posedge tx_bit_clock) begin
      if (lrst) begin
         tx_st <= pcmsig_pkg::st_idle;
         tcnt <= 3'd0;
         tsh <= '0;
         tx_pcm_out <= 1'b0;
         tx_pcm_oe <= 1'b0;
         tx_tog <= 1'b0;
      end else if (lce) begin
         case (tx_st)
            pcmsig_pkg::st_idle: begin
               // R8: previous frame's code goes out now
               if (tx_start) begin
                  tsh <= out_word;
                  tx_pcm_out <= out_word[`PCMSIG_MSB];
                  tx_pcm_oe <= 1'b1;
                  tcnt <= 3'd0;
                  tx_tog <= !tx_tog;
                  tx_st <= pcmsig_pkg::st_shift;
               end
            end
            pcmsig_pkg::st_shift: begin
               // R13: release after eight periods
               if (tcnt == 3'd7) begin
                  tx_pcm_oe <= 1'b0;
                  tx_st <= pcmsig_pkg::st_idle;
               end else begin
                  tcnt <= tcnt + 3'd1;
                  tsh <= {tsh[6:0], 1'b0};
                  // R1: signaling level replaces the LSB
                  // R5: no insertion unless flagged
                  if (tcnt == 3'd6 && tx_sig) begin
                     tx_pcm_out <= sig_in;
                  end else begin
                     tx_pcm_out <= tsh[6];
                  end
               end
            end
            default: tx_st <= pcmsig_pkg::st_idle;
         endcase
      end
   end

   // Receive sync width and signaling flag on falling edges
   always_ff @(negedge tx_bit_clock) begin
      if (lrst) begin
         rxfs_q <= 1'b0;
         rxw <= 2'd0;
         rx_sig <= 1'b0;
      end else if (lce) begin
         rxfs_q <= rx_frame_sync;
         if (rx_frame_sync) begin
            rxw <= (rxw == `PCMSIG_LONG_W) ? rxw : rxw + 2'd1;
            if (!rxfs_q) begin
               rx_sig <= 1'b0;
            end else if (long_mode && LONG_SIG_EN && rx_signaling_frame_mark) begin
               // R7: marker flags signaling frame
               rx_sig <= 1'b1;
            end
         end else begin
            rxw <= 2'd0;
            // R2: two-period sync flags signaling only while long_mode is clear
            if (rxfs_q && rxw == `PCMSIG_SIG_W && !long_mode) begin
               rx_sig <= 1'b1;
            end
         end
      end
   end

   // Receive shifter on falling edges
   always_ff @(negedge tx_bit_clock) begin
      if (lrst) begin
         rx_st <= pcmsig_pkg::st_idle;
         rcnt <= 3'd0;
         rsh <= '0;
         rx_hold <= '0;
         rx_tog <= 1'b0;
         rx_signal_bit_out <= 1'b0;
      end else if (lce) begin
         case (rx_st)
            pcmsig_pkg::st_idle: begin
               if (rx_frame_sync && !rxfs_q) begin
                  rcnt <= 3'd0;
                  rx_st <= pcmsig_pkg::st_shift;
               end
            end
            pcmsig_pkg::st_shift: begin
               // R9: one bit per falling edge
               rsh <= {rsh[5:0], rx_pcm_in};
               rcnt <= rcnt + 3'd1;
               if (rx_fin) begin
                  rx_tog <= !rx_tog;
                  rx_st <= pcmsig_pkg::st_idle;
                  if (rx_sig) begin
                     // R15: output refreshed only here
                     // R2: LSB latched to the output
                     rx_signal_bit_out <= rx_pcm_in;
                     // R3: stolen LSB read as half step
                     rx_hold <= {rsh, 2'b01};
                  end else begin
                     rx_hold <= {rsh, rx_pcm_in, 1'b0};
                  end
               end
            end
            default: rx_st <= pcmsig_pkg::st_idle;
         endcase
      end
   end

   // Frame toggles into the system domain
   always_ff @(posedge clk) begin
      if (rst) begin
         txt_s <= 3'd0;
         rxt_s <= 3'd0;
      end else if (ce) begin
         txt_s <= {txt_s[1:0], tx_tog};
         rxt_s <= {rxt_s[1:0], rx_tog};
      end
   end

   // Encoder side: take codes, keep one frame of lag
   always_ff @(posedge clk) begin
      if (rst) begin
         pend <= `PCMSIG_CODE_RST;
         out_word <= `PCMSIG_CODE_RST;
         tx_code_ready <= 1'b1;
      end else if (ce) begin
         // R8: sample at this sync, send at the next
         if (tx_ev) begin
            out_word <= pend;
            tx_code_ready <= 1'b1;
         end
         if (tx_code_valid && tx_code_ready) begin
            pend <= tx_code;
            tx_code_ready <= 1'b0;
         end
      end
   end

   // Decoder side: hold the word for the update delay, then buffer it
   always_ff @(posedge clk) begin
      if (rst) begin
         dec_cnt <= 9'd0;
         push_v <= 1'b0;
         push_d <= '0;
      end else if (ce) begin
         // Clear first, so a word that becomes due now is not lost
         if (push_v && rxb.in_ready) begin
            push_v <= 1'b0;
         end
         if (rx_ev) begin
            push_d <= rx_hold;
            dec_cnt <= 9'(`PCMSIG_DEC_CYC);
         end else if (dec_cnt != 9'd0) begin
            // R10: update after the decode delay
            dec_cnt <= dec_cnt - 9'd1;
            if (dec_cnt == 9'd1) begin
               push_v <= 1'b1;
            end
         end
      end
   end

   assign rxb.in_valid = push_v;
   assign rxb.in_data = push_d;
   assign rxb.out_ready = rx_sample_ready;
   assign rx_sample = rxb.out_data;
   assign rx_sample_valid = rxb.out_valid;

   // Buffer between decoder and its reader
   pcmsig_fifo2 u_buf (
      .clk (clk),
      .rst (rst),
      .ce (ce),
      .bus (rxb.store)
   );

   // Filter step clock from the master clock
   always_ff @(posedge clk) begin
      if (rst) begin
         mck_s <= 3'd0;
         fdiv <= 3'd0;
         filter_clock <= 1'b0;
      end else if (ce) begin
         mck_s <= {mck_s[1:0], tx_master_clock};
         // R11: divide master clock to 256 kHz
         if (mck_s[1] && !mck_s[2]) begin
            if (fdiv == 3'(`PCMSIG_FILT_HALF - 1)) begin
               fdiv <= 3'd0;
               filter_clock <= !filter_clock;
            end else begin
               fdiv <= fdiv + 3'd1;
            end
         end
      end
   end

   // ---------------- Checks ----------------
   a_dec_delay: assert property (@(posedge clk) disable iff (rst || !ce) // R10
      rx_ev |-> ##[1:DEC_MAX] push_v)
      else $error("decoded word not offered in time");
   a_push_hold: assert property (@(posedge clk) disable iff (rst || !ce) // R10
      push_v && !rxb.in_ready |=> push_v && $stable(push_d))
      else $error("decoded word dropped under stall");
   a_frame_lag: assert property (@(posedge clk) disable iff (rst || !ce) // R8
      tx_ev |=> out_word == $past(pend))
      else $error("transmit code lag wrong");
   a_code_rearm: assert property (@(posedge clk) disable iff (rst || !ce) // R8
      tx_ev && !tx_code_valid |=> tx_code_ready)
      else $error("code input not rearmed at frame");
   a_tx_oe_len: assert property (@(posedge tx_bit_clock) disable iff (lrst || !lce) // R13
      $rose(tx_pcm_oe) |-> tx_pcm_oe [*8] ##1 !tx_pcm_oe)
      else $error("output enable not eight periods");
   a_tx_first: assert property (@(posedge tx_bit_clock) disable iff (lrst || !lce) // R13
      tx_start |=> tx_pcm_oe && tx_pcm_out == $past(out_word[7]))
      else $error("sign bit not first");
   a_tx_sig_lsb: assert property (@(posedge tx_bit_clock) disable iff (lrst || !lce) // R1
      tx_st == pcmsig_pkg::st_shift && tcnt == 3'd6 && tx_sig |=> tx_pcm_out == $past(sig_in))
      else $error("signaling bit not inserted");
   a_rx_sig_hold: assert property (@(negedge tx_bit_clock) disable iff (lrst || !lce) // R15
      !(rx_fin && rx_sig) |=> $stable(rx_signal_bit_out))
      else $error("signaling output moved outside signaling frame");
   a_rx_half: assert property (@(negedge tx_bit_clock) disable iff (lrst || !lce) // R3
      rx_fin && rx_sig |=> rx_hold[1:0] == 2'b01 && rx_signal_bit_out == $past(rx_pcm_in))
      else $error("half step or signaling latch wrong");
   a_filt_step: assert property (@(posedge clk) disable iff (rst || !ce) // R11
      $changed(filter_clock) |-> $past(mck_s[1] && !mck_s[2]))
      else $error("filter clock moved without master edge");
endmodule
`default_nettype wire

/* File: sim/pcmsig_hwy_model.sv */
// Highway controller model: bit clock, frame syncs, markers and PCM traffic
`default_nettype none
module pcmsig_hwy_model (
   // Bit clock
   output logic tx_bit_clock,
   // Frame syncs and signaling markers
   output logic tx_frame_sync,
   output logic rx_frame_sync,
   output logic tx_signaling_frame_mark,
   output logic rx_signaling_frame_mark,
   // Signaling bit and receive data
   output logic tx_signal_bit_in,
   output logic rx_pcm_in,
   // Transmit data from the port
   input wire logic tx_pcm_out,
   input wire logic tx_pcm_oe
);
   timeunit 1ns;
   timeprecision 100ps;

   // Bit clock of 80 ns, phase unrelated to the system clock
   initial begin
      tx_bit_clock = 1'b0;
      #7;
      forever #40 tx_bit_clock = ~tx_bit_clock;
   end

   // Idle highway levels
   initial begin
      tx_frame_sync = 1'b0;
      rx_frame_sync = 1'b0;
      tx_signaling_frame_mark = 1'b0;
      rx_signaling_frame_mark = 1'b0;
      tx_signal_bit_in = 1'b0;
      rx_pcm_in = 1'b0;
   end

   // One frame: sync width in bit periods, marker, signaling bit and receive word
   task automatic frame(input int width, input logic mark, input logic sig, input logic [7:0] rx_word,
         output logic [7:0] tx_word, output logic oe_ok);
      int i;
      oe_ok = 1'b1;
      tx_word = 8'h00;
      tx_signal_bit_in = sig;
      @(posedge tx_bit_clock);
      #1;
      tx_frame_sync = 1'b1;
      rx_frame_sync = 1'b1;
      // markers low in short frames, held with the sync otherwise
      tx_signaling_frame_mark = mark;
      rx_signaling_frame_mark = mark;
      for (i = 0; i < 9; i++) begin
         @(posedge tx_bit_clock);
         #1;
         // sync lasts the given bit periods
         if (i + 1 == width) begin
            tx_frame_sync = 1'b0;
            rx_frame_sync = 1'b0;
            tx_signaling_frame_mark = 1'b0;
            rx_signaling_frame_mark = 1'b0;
         end
         // one bit a period, MSB first; the released line shows the inverse
         rx_pcm_in = (i < 8) ? rx_word[7 - i] : ~rx_pcm_in;
         @(negedge tx_bit_clock);
         if (i < 8) begin
            tx_word[7 - i] = tx_pcm_out;
         end
         if (tx_pcm_oe !== (i < 8)) begin
            oe_ok = 1'b0;
         end
      end
   endtask

   // Idle bit periods between frames
   task automatic idle(input int n);
      repeat (n) @(posedge tx_bit_clock);
   endtask
endmodule
`default_nettype wire

/* File: sim/testbench.sv */
// Self-checking bench of the PCM signaling-bit port
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   // System side
   logic clk, rst, ce, tx_code_valid, tx_code_ready, rx_sample_valid, rx_sample_ready;
   logic [7:0] tx_code;
   logic [8:0] rx_sample;
   logic tx_master_clock, filter_clock;
   // Highway
   logic tx_bit_clock, tx_frame_sync, rx_frame_sync, tx_signaling_frame_mark, rx_signaling_frame_mark;
   logic tx_signal_bit_in, rx_pcm_in, tx_pcm_out, tx_pcm_oe, rx_signal_bit_out, short_signal_bit;
   // Bookkeeping
   int fails, n_compared;
   int filt_n = 0;
   logic [7:0] prev_code, frame_n;
   logic exp_sig;
   logic [8:0] exp_q[$];

   // Port with long-frame markers honoured
   pcmsig_port #(.LONG_SIG_EN(1'b1)) u_pcmsig_port (.clk, .rst, .ce, .tx_code, .tx_code_valid,
      .tx_code_ready, .rx_sample, .rx_sample_valid, .rx_sample_ready, .tx_master_clock, .filter_clock,
      .tx_bit_clock, .tx_frame_sync, .rx_frame_sync, .tx_signaling_frame_mark, .rx_signaling_frame_mark,
      .tx_signal_bit_in, .rx_pcm_in, .tx_pcm_out, .tx_pcm_oe, .rx_signal_bit_out);
   // Short-only variant beside it, watched on its signaling output
   pcmsig_port #(.LONG_SIG_EN(1'b0)) u_pcmsig_port_short (.clk, .rst, .ce, .tx_code, .tx_code_valid,
      .tx_code_ready(), .rx_sample(), .rx_sample_valid(), .rx_sample_ready, .tx_master_clock,
      .filter_clock(), .tx_bit_clock, .tx_frame_sync, .rx_frame_sync, .tx_signaling_frame_mark,
      .rx_signaling_frame_mark, .tx_signal_bit_in, .rx_pcm_in, .tx_pcm_out(), .tx_pcm_oe(),
      .rx_signal_bit_out(short_signal_bit));
   // Highway controller
   pcmsig_hwy_model u_pcmsig_hwy_model (.tx_bit_clock, .tx_frame_sync, .rx_frame_sync,
      .tx_signaling_frame_mark, .rx_signaling_frame_mark, .tx_signal_bit_in, .rx_pcm_in, .tx_pcm_out, .tx_pcm_oe);

   // System clock, 20 ns
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // Master clock near 2.048 MHz
   initial begin
      tx_master_clock = 1'b0;
      #3;
      forever #244 tx_master_clock = ~tx_master_clock;
   end

   // Filter clock step counter
   always @(posedge filter_clock) begin
      filt_n <= filt_n + 1;
   end

   // Compare and count
   task automatic check(input string what, input logic [8:0] seen, input logic [8:0] expected);
      n_compared++;
      if (seen !== expected) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", what, expected, seen);
      end
   endtask

   // Verdict and end of run
   task automatic give_verdict;
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // Hand one code to the encoder input
   task automatic offer_code(input logic [7:0] c);
      int n;
      n = 0;
      @(posedge clk);
      #1;
      while (tx_code_ready !== 1'b1 && n < 100) begin
         @(posedge clk);
         #1;
         n++;
      end
      check("code ready", tx_code_ready, 1'b1);
      tx_code = c;
      tx_code_valid = 1'b1;
      @(posedge clk);
      #1;
      tx_code_valid = 1'b0;
      check("code taken", tx_code_ready, 1'b0);
   endtask

   // One frame both ways, judged at the highway
   task automatic run_frame(input int width, input logic mark, input logic sig, input logic [7:0] rxw,
         input logic sigf);
      logic [7:0] txw, code;
      logic oe_ok;
      code = {frame_n[3:0] + 4'h9, 3'b011, (frame_n == 8'h00)};
      frame_n++;
      offer_code(code);
      u_pcmsig_hwy_model.frame(width, mark, sig, rxw, txw, oe_ok);
      check("tx word", txw, sigf ? {prev_code[7:1], sig} : prev_code);
      prev_code = code;
      check("oe window", oe_ok, 1'b1);
      if (exp_q.size() == 0) begin
         check("decode early", rx_sample_valid, 1'b0);
      end
      if (sigf) begin
         exp_sig = rxw[0];
      end
      check("signal out", rx_signal_bit_out, exp_sig);
      exp_q.push_back(sigf ? {rxw[7:1], 2'b01} : {rxw, 1'b0});
      u_pcmsig_hwy_model.idle(132);
   endtask

   // Take one decoded word and compare
   task automatic fetch;
      logic [8:0] e;
      e = exp_q.pop_front();
      repeat (2) @(posedge clk);
      #1;
      check("decode done", rx_sample_valid, 1'b1);
      check("rx sample", rx_sample, e);
      rx_sample_ready = 1'b1;
      @(posedge clk);
      #1;
      rx_sample_ready = 1'b0;
   endtask

   // Short frames, plain and signaling
   task automatic t_short;
      run_frame(1, 1'b0, 1'b0, 8'ha5, 1'b0);
      fetch;
      run_frame(2, 1'b0, 1'b0, 8'h3b, 1'b1);
      fetch;
      run_frame(1, 1'b0, 1'b1, 8'h52, 1'b0);
      fetch;
      run_frame(2, 1'b0, 1'b1, 8'hc6, 1'b1);
      fetch;
      $display("short frame test done");
   endtask

   // Reader stalls over two frames, then drains
   task automatic t_stall;
      run_frame(1, 1'b0, 1'b1, 8'h71, 1'b0);
      run_frame(2, 1'b0, 1'b1, 8'h9d, 1'b1);
      fetch;
      fetch;
      $display("stall test done");
   endtask

   // Enable low freezes the port through a whole signaling frame
   task automatic t_freeze;
      logic [7:0] txw;
      logic oe_ok;
      @(posedge clk);
      #1;
      ce = 1'b0;
      u_pcmsig_hwy_model.idle(4);
      u_pcmsig_hwy_model.frame(2, 1'b0, ~exp_sig, {7'h1d, ~exp_sig}, txw, oe_ok);
      check("frozen oe", oe_ok, 1'b0);
      check("frozen signal", rx_signal_bit_out, exp_sig);
      @(posedge clk);
      #1;
      ce = 1'b1;
      u_pcmsig_hwy_model.idle(4);
      $display("enable freeze test done");
   endtask

   // Long frames with and without the marker
   task automatic t_long;
      logic held;
      held = short_signal_bit;
      run_frame(3, 1'b0, 1'b1, 8'h18, 1'b0);
      fetch;
      run_frame(4, 1'b1, 1'b1, 8'he6, 1'b1);
      fetch;
      run_frame(3, 1'b0, 1'b0, 8'h2c, 1'b0);
      fetch;
      check("short variant", short_signal_bit, held);
      $display("long frame test done");
   endtask

   // Filter clock against the master clock
   task automatic t_filter;
      int n0;
      @(posedge filter_clock);
      #1;
      n0 = filt_n;
      repeat (164) @(posedge tx_master_clock);
      check("filter steps", 9'(filt_n - n0), 9'h014);
      $display("filter clock test done");
   endtask

   // Main sequence
   initial begin
      rst = 1'b1;
      ce = 1'b1;
      tx_code = 8'h00;
      tx_code_valid = 1'b0;
      rx_sample_ready = 1'b0;
      fails = 0;
      n_compared = 0;
      prev_code = 8'hff;
      frame_n = 8'h00;
      exp_sig = 1'b0;
      // Long enough for the bit clock domain to see it
      repeat (16) @(posedge clk);
      #1;
      check("reset ready", tx_code_ready, 1'b1);
      check("reset oe", tx_pcm_oe, 1'b0);
      rst = 1'b0;
      u_pcmsig_hwy_model.idle(4);
      t_short;
      t_stall;
      t_freeze;
      t_long;
      t_filter;
      give_verdict;
   end

   // Watchdog
   initial begin
      #400000;
      fails++;
      $display("watchdog expired");
      give_verdict;
   end
endmodule
`default_nettype wire
